/* hw/srb_pkg.sv */
package srb_pkg;

	// ----------------------------------------
	// Fixed boot strap values
	// ----------------------------------------
	localparam logic [15:0] SRB_STRAP_UPPER_RST = 16'h5100; // 0,10,1,0,0,01,000 in [15:5]
	localparam logic [4:0] SRB_BOOT_ORDER_DEF = 5'h17; // 10111
	localparam int SRB_BOOT_ORDER_POS = 0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SRB_CLK_NS = 100;
	localparam int SRB_PWR_SETTLE_US = 10;
	localparam int SRB_PWR_SETTLE_CYC = (SRB_PWR_SETTLE_US * 1000 + SRB_CLK_NS - 1) / SRB_CLK_NS;
	localparam int SRB_CPU_RST_US = 5;
	localparam int SRB_CPU_RST_CYC = (SRB_CPU_RST_US * 1000 + SRB_CLK_NS - 1) / SRB_CLK_NS;
	localparam logic [31:0] SRB_EMPTY_WORD = 32'hffffffff;
	localparam int SRB_MUX_FUNCS = 7;
	localparam int SRB_MUX_PINS = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRB_SRC_MMC = 3'h0,
		SRB_SRC_SPI = 3'h1,
		SRB_SRC_UART = 3'h2,
		SRB_SRC_NET = 3'h3,
		SRB_SRC_NONE = 3'h4
	} srb_src_type;

	typedef enum logic [2:0] {
		SRB_ST_OFF = 3'h0,
		SRB_ST_SETTLE = 3'h1,
		SRB_ST_CPU_RST = 3'h2,
		SRB_ST_BOOT = 3'h3,
		SRB_ST_RUN = 3'h4,
		SRB_ST_FAIL = 3'h5
	} srb_state_type;

	typedef struct packed {
		logic pmic_cold_reset_in;
		logic external_warm_reset_n;
		logic jtag_trst_n;
		logic monitor_ok;
	} srb_rst_in_type;

	typedef struct packed {
		logic done;
		logic ok;
		logic [31:0] first_word;
	} srb_probe_type;

endpackage

/* hw/srb_seq.sv */
`timescale 1ns/1ps
// Function
// - Carrier enable low when supply applied
// - Raise carrier enable once, then hold
// - Cold reset holds power manager off
// - Power-on reset is shared open-drain node
// - Voltage monitor pulls power-on reset low
// - Peripheral reset held until processor runs
// - Low warm reset input resets processor
// - Test reset input gives emulation reset
// - Fixed upper boot strap values
// - Boot order strap defaults to 10111
// - Default strap tries MMC, SPI, UART, network; others try SPI, UART, MMC, network
// - All-ones first SPI word means empty
// - SPI boot loads loader into SRAM
// - Card boot uses card interface one
// - Pin mux picks one of seven functions
module srb_seq
	import srb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Reset pins
	input wire srb_rst_in_type rst_pins,
	input wire logic power_on_reset_line_n_in,
	output logic power_on_reset_line_n_out,
	output logic power_on_reset_line_n_oe,
	// Power outputs
	output logic carrier_power_enable,
	output logic pmic_hard_reset,
	output logic cpu_power_on_input_n,
	output logic cpu_warm_reset_n,
	output logic cpu_emu_reset_n,
	output logic peripheral_reset_out_n,
	// Boot straps
	input wire logic [4:0] boot_strap_pin,
	output logic [15:0] boot_strap_bits,
	// Boot source probing
	output logic [2:0] boot_source,
	output logic boot_probe_req,
	output logic boot_card_if_one,
	output logic boot_load_sram,
	input wire srb_probe_type probe,
	output logic boot_done,
	output logic boot_failed,
	// Pin multiplexing
	input wire logic [SRB_MUX_PINS*3-1:0] mux_sel,
	input wire logic [SRB_MUX_PINS*SRB_MUX_FUNCS-1:0] mux_func_data,
	output logic [SRB_MUX_PINS-1:0] mux_pin_data
);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [4:0] rsync;
	logic [4:0] strap_s;
	logic cold_s;
	logic warm_n_s;
	logic trst_n_s;
	logic mon_ok_s;
	logic por_line_s;

	srb_sync #(.WIDTH(5), .INIT(5'h0e)) u_rsync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din({rst_pins.pmic_cold_reset_in, rst_pins.external_warm_reset_n,
			rst_pins.jtag_trst_n, rst_pins.monitor_ok, power_on_reset_line_n_in}),
		.dout(rsync)
	);

	srb_sync #(.WIDTH(5), .INIT(SRB_BOOT_ORDER_DEF)) u_strap (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(boot_strap_pin),
		.dout(strap_s)
	);

	assign cold_s = rsync[4];
	assign warm_n_s = rsync[3];
	assign trst_n_s = rsync[2];
	assign mon_ok_s = rsync[1];
	assign por_line_s = rsync[0];

	// ----------------------------------------
	// Shared power-on reset node
	// ----------------------------------------
	logic por_pull_r;
	logic por_pull_nxt;
	logic por_active;

	// Monitor or cold reset pull node low
	assign por_pull_nxt = !mon_ok_s || cold_s;
	assign por_active = por_pull_r || !por_line_s;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	srb_state_type state_r;
	srb_state_type state_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	srb_src_type src_r;
	srb_src_type src_nxt;
	logic [4:0] order_r;
	logic en_r;
	logic en_nxt;
	logic req_r;
	logic req_nxt;
	logic spi_empty;
	logic probe_good;

	function automatic srb_src_type next_src(input srb_src_type cur, input logic [4:0] order);
		srb_src_type n;
		n = SRB_SRC_NONE;
		if (order == SRB_BOOT_ORDER_DEF) begin
			case (cur)
				SRB_SRC_MMC: n = SRB_SRC_SPI;
				SRB_SRC_SPI: n = SRB_SRC_UART;
				SRB_SRC_UART: n = SRB_SRC_NET;
				default: n = SRB_SRC_NONE;
			endcase
		end else begin
			case (cur)
				SRB_SRC_SPI: n = SRB_SRC_UART;
				SRB_SRC_UART: n = SRB_SRC_MMC;
				SRB_SRC_MMC: n = SRB_SRC_NET;
				default: n = SRB_SRC_NONE;
			endcase
		end
		return n;
	endfunction

	assign spi_empty = (src_r == SRB_SRC_SPI) && (probe.first_word == SRB_EMPTY_WORD);
	assign probe_good = probe.ok && !spi_empty;

	// Next state; enable only falls on power-on reset
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		src_nxt = src_r;
		en_nxt = en_r;
		req_nxt = 1'b0;
		if (por_active) begin
			state_nxt = SRB_ST_OFF;
			en_nxt = 1'b0;
			cnt_nxt = 16'h0;
		end else begin
			case (state_r)
				SRB_ST_OFF: begin
					state_nxt = SRB_ST_SETTLE;
					cnt_nxt = 16'h0;
				end
				SRB_ST_SETTLE: begin
					cnt_nxt = cnt_r + 16'h1;
					if (cnt_r == 16'(SRB_PWR_SETTLE_CYC - 1)) begin
						en_nxt = 1'b1;
						state_nxt = SRB_ST_CPU_RST;
						cnt_nxt = 16'h0;
					end
				end
				SRB_ST_CPU_RST: begin
					cnt_nxt = cnt_r + 16'h1;
					if (cnt_r == 16'(SRB_CPU_RST_CYC - 1)) begin
						state_nxt = SRB_ST_BOOT;
						src_nxt = (order_r == SRB_BOOT_ORDER_DEF) ? SRB_SRC_MMC : SRB_SRC_SPI;
						req_nxt = 1'b1;
					end
				end
				SRB_ST_BOOT: begin
					if (probe.done && !req_r) begin
						if (probe_good) begin
							state_nxt = SRB_ST_RUN;
						end else begin
							src_nxt = next_src(src_r, order_r);
							if (next_src(src_r, order_r) == SRB_SRC_NONE) begin
								state_nxt = SRB_ST_FAIL;
							end else begin
								req_nxt = 1'b1;
							end
						end
					end
				end
				SRB_ST_RUN: state_nxt = SRB_ST_RUN;
				SRB_ST_FAIL: state_nxt = SRB_ST_FAIL;
				default: state_nxt = SRB_ST_OFF;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= SRB_ST_OFF;
			cnt_r <= 16'h0;
			src_r <= SRB_SRC_MMC;
			en_r <= 1'b0;
			req_r <= 1'b0;
			por_pull_r <= 1'b1;
			order_r <= SRB_BOOT_ORDER_DEF;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			src_r <= src_nxt;
			en_r <= en_nxt;
			req_r <= req_nxt;
			por_pull_r <= por_pull_nxt;
			if (state_r == SRB_ST_CPU_RST && cnt_r == 16'h0) begin
				order_r <= strap_s;
			end
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	logic [SRB_MUX_PINS-1:0] mux_nxt;

	// Only selected function drives each pin
	always_comb begin
		for (int p = 0; p < SRB_MUX_PINS; p++) begin
			mux_nxt[p] = 1'b0;
			for (int f = 0; f < SRB_MUX_FUNCS; f++) begin
				if (mux_sel[p*3 +: 3] == 3'(f)) begin
					mux_nxt[p] = mux_func_data[p*SRB_MUX_FUNCS + f];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			carrier_power_enable <= 1'b0;
			pmic_hard_reset <= 1'b1;
			power_on_reset_line_n_out <= 1'b0;
			power_on_reset_line_n_oe <= 1'b1;
			cpu_power_on_input_n <= 1'b0;
			cpu_warm_reset_n <= 1'b0;
			cpu_emu_reset_n <= 1'b0;
			peripheral_reset_out_n <= 1'b0;
			boot_strap_bits <= SRB_STRAP_UPPER_RST | 16'(SRB_BOOT_ORDER_DEF);
			boot_source <= 3'h4;
			boot_probe_req <= 1'b0;
			boot_card_if_one <= 1'b0;
			boot_load_sram <= 1'b0;
			boot_done <= 1'b0;
			boot_failed <= 1'b0;
			mux_pin_data <= '0;
		end else begin
			carrier_power_enable <= en_nxt;
			pmic_hard_reset <= cold_s;
			power_on_reset_line_n_out <= 1'b0;
			power_on_reset_line_n_oe <= por_pull_nxt;
			cpu_power_on_input_n <= !por_active;
			cpu_warm_reset_n <= warm_n_s;
			cpu_emu_reset_n <= trst_n_s;
			peripheral_reset_out_n <= (state_nxt == SRB_ST_RUN);
			boot_strap_bits <= SRB_STRAP_UPPER_RST | 16'(strap_s);
			boot_source <= (state_nxt == SRB_ST_BOOT) ? 3'(src_nxt) : 3'h4;
			boot_probe_req <= req_nxt;
			boot_card_if_one <= (state_nxt == SRB_ST_BOOT) && (src_nxt == SRB_SRC_MMC);
			boot_load_sram <= (state_r == SRB_ST_BOOT) && probe.done && probe_good
				&& (src_r == SRB_SRC_SPI);
			boot_done <= (state_nxt == SRB_ST_RUN);
			boot_failed <= (state_nxt == SRB_ST_FAIL);
			mux_pin_data <= mux_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_en_stays;
		@(posedge clk_sys) disable iff (rst)
		carrier_power_enable && !por_active |=> carrier_power_enable;
	endproperty
	a_en_stays: assert property (p_en_stays) else $error("enable dropped");

	property p_en_rise;
		@(posedge clk_sys) disable iff (rst)
		$rose(carrier_power_enable) |-> $past(state_r) == SRB_ST_SETTLE;
	endproperty
	a_en_rise: assert property (p_en_rise) else $error("enable rose outside settle");

	property p_por_low;
		@(posedge clk_sys) disable iff (rst)
		por_active |=> !carrier_power_enable;
	endproperty
	a_por_low: assert property (p_por_low) else $error("enable high in reset");

	property p_periph;
		@(posedge clk_sys) disable iff (rst)
		state_r != SRB_ST_RUN |-> !peripheral_reset_out_n;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral reset early");

	property p_straps;
		@(posedge clk_sys) disable iff (rst)
		boot_strap_bits[15:5] == SRB_STRAP_UPPER_RST[15:5];
	endproperty
	a_straps: assert property (p_straps) else $error("upper straps wrong");

	property p_empty;
		@(posedge clk_sys) disable iff (rst)
		state_r == SRB_ST_BOOT && probe.done && !req_r && spi_empty && !por_active
			|=> src_r == SRB_SRC_UART;
	endproperty
	a_empty: assert property (p_empty) else $error("empty flash not skipped");

	property p_cold;
		@(posedge clk_sys) disable iff (rst)
		cold_s |=> pmic_hard_reset ##1 !carrier_power_enable;
	endproperty
	a_cold: assert property (p_cold) else $error("cold reset ignored");

	property p_warm;
		@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> cpu_warm_reset_n == $past(warm_n_s)
			&& cpu_emu_reset_n == $past(trst_n_s);
	endproperty
	a_warm: assert property (p_warm) else $error("warm reset not passed");

endmodule

/* hw/srb_sync.sv */
`timescale 1ns/1ps
module srb_sync
	import srb_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] dout_r;
	logic [WIDTH-1:0] dout_nxt;

	// Accept per bit once stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			dout_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : dout_r[i];
		end
	end

	// Three stage chain
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			dout_r <= INIT;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dout_r <= dout_nxt;
		end
	end

	assign dout = dout_r;

endmodule

/* verif/srb_carrier.sv */
`timescale 1ns/1ps
module srb_carrier
	import srb_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Sequencer side
	input wire logic carrier_power_enable,
	input wire logic power_on_reset_line_n_out,
	input wire logic power_on_reset_line_n_oe,
	input wire logic [2:0] boot_source,
	input wire logic boot_probe_req,
	input wire logic peripheral_reset_out_n,
	output logic power_on_reset_line_n_in,
	output srb_probe_type probe,
	output logic carrier_3v3_on,
	output logic carrier_dev_reset_n,
	// Scenario control
	input wire logic [3:0] ok_mask,
	input wire logic spi_empty,
	input wire logic [1:0] delay
);
	logic [1:0] cnt_r = 2'h0;
	logic busy_r = 1'b0;
	initial probe = '0;
	// Wired node, pull-up wins when nobody pulls
	assign power_on_reset_line_n_in = power_on_reset_line_n_oe ? power_on_reset_line_n_out : 1'b1;
	// Carrier 3.3V devices only follow a high enable
	assign carrier_3v3_on = carrier_power_enable;
	// Buffered copy of peripheral reset for carrier loads
	assign carrier_dev_reset_n = peripheral_reset_out_n;
	// Probe responder, word toggles when not answering
	always @(posedge clk_sys) begin
		probe.done <= 1'b0;
		probe.ok <= 1'b0;
		probe.first_word <= ~probe.first_word;
		if (boot_probe_req) begin
			busy_r <= 1'b1;
			cnt_r <= delay;
		end else if (busy_r && cnt_r == 2'h0) begin
			busy_r <= 1'b0;
			probe.done <= 1'b1;
			probe.ok <= ok_mask[boot_source[1:0]];
			probe.first_word <= (boot_source == SRB_SRC_SPI && spi_empty) ? 32'hffffffff
				: 32'h12345678;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
	import srb_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	srb_rst_in_type rst_pins = 4'h7;
	logic por_in, por_out, por_oe, en, hard, cpu_por_n, warm_n, emu_n, per_n;
	logic req, card, sram, done, failed, carrier_on, dev_rst_n, spi_empty = 1'b0;
	logic [4:0] strap_pin = 5'h17;
	logic [15:0] strap_bits;
	logic [2:0] src;
	srb_probe_type probe;
	logic [11:0] mux_sel = 12'h0;
	logic [27:0] mux_data = 28'h0;
	logic [3:0] mux_out, ok_mask = 4'h0, mux_exp;
	logic [1:0] delay = 2'h0;
	logic [2:0] exp_src[$];
	int mismatches = 0;
	int comparisons = 0;
	// Clock
	always #50 clk_sys = ~clk_sys;
	srb_seq srb_seq_inst (.clk_sys(clk_sys), .rst(rst), .rst_pins(rst_pins),
		.power_on_reset_line_n_in(por_in), .power_on_reset_line_n_out(por_out),
		.power_on_reset_line_n_oe(por_oe), .carrier_power_enable(en), .pmic_hard_reset(hard),
		.cpu_power_on_input_n(cpu_por_n), .cpu_warm_reset_n(warm_n), .cpu_emu_reset_n(emu_n),
		.peripheral_reset_out_n(per_n), .boot_strap_pin(strap_pin), .boot_strap_bits(strap_bits),
		.boot_source(src), .boot_probe_req(req), .boot_card_if_one(card), .boot_load_sram(sram),
		.probe(probe), .boot_done(done), .boot_failed(failed), .mux_sel(mux_sel),
		.mux_func_data(mux_data), .mux_pin_data(mux_out));
	srb_carrier srb_carrier_inst (.clk_sys(clk_sys), .carrier_power_enable(en),
		.power_on_reset_line_n_out(por_out), .power_on_reset_line_n_oe(por_oe),
		.boot_source(src), .boot_probe_req(req), .power_on_reset_line_n_in(por_in),
		.peripheral_reset_out_n(per_n), .carrier_dev_reset_n(dev_rst_n),
		.probe(probe), .carrier_3v3_on(carrier_on), .ok_mask(ok_mask), .spi_empty(spi_empty),
		.delay(delay));
	task automatic end_sim;
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// Each probe start takes the oldest expected source
	always @(posedge clk_sys) begin
		if (req === 1'b1 && exp_src.size() == 0) check(src, 3'h7, "extra probe");
		else if (req === 1'b1) check(src, exp_src.pop_front(), "probe source");
		if (req === 1'b1) check(card, src === SRB_SRC_MMC, "card one");
	end
	task automatic boot_run(input logic [3:0] mask, input logic empty, input logic alt);
		int n;
		logic good, sram_seen, drop, sram_exp;
		logic [11:0] ord;
		logic [2:0] cur;
		good = 1'b0;
		sram_seen = 1'b0;
		drop = 1'b0;
		sram_exp = 1'b0;
		ord = alt ? 12'h611 : 12'h688;
		ok_mask <= mask;
		spi_empty <= empty;
		delay <= 2'($urandom);
		strap_pin <= alt ? 5'h0a : 5'h17;
		for (int s = 0; s < 4 && !good; s++) begin
			cur = ord[s*3+:3];
			exp_src.push_back(cur);
			good = mask[cur[1:0]] && !(cur == 3'h1 && empty);
			sram_exp = good && cur == 3'h1;
		end
		rst_pins.monitor_ok <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check(por_in, 1'b0, "node pulled");
		check(en, 1'b0, "enable after por");
		check(per_n, 1'b0, "periph reset");
		check(cpu_por_n, 1'b0, "cpu por held");
		check(carrier_on, 1'b0, "carrier off");
		rst_pins.monitor_ok <= 1'b1;
		for (n = 0; en !== 1'b1 && n < 300; n++) @(posedge clk_sys);
		check(n >= SRB_PWR_SETTLE_CYC && n < 300, 1'b1, "enable rise");
		check(carrier_on, 1'b1, "carrier on");
		for (n = 0; done !== 1'b1 && failed !== 1'b1 && n < 3000; n++) begin
			@(posedge clk_sys);
			sram_seen |= (sram === 1'b1);
			drop |= (en !== 1'b1);
		end
		check(drop, 1'b0, "enable held");
		check({done, failed}, {good, !good}, "boot end");
		check(per_n, good, "periph release");
		check(dev_rst_n, good, "carrier dev reset");
		check(cpu_por_n, 1'b1, "cpu por released");
		check(src, 3'h4, "source idle");
		check(sram_seen, sram_exp, "sram load");
		check(exp_src.size(), 0, "sources left");
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'h4d5b3076));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check(en, 1'b0, "enable at power");
		strap_pin <= 5'($urandom);
		repeat (6) @(posedge clk_sys);
		check(strap_bits, {11'h288, strap_pin}, "straps");
		strap_pin <= 5'h17;
		repeat (6) @(posedge clk_sys);
		check(strap_bits, 16'h5117, "default straps");
		for (int i = 0; i < 12; i++) begin
			mux_sel <= 12'($urandom);
			mux_data <= 28'($urandom);
			@(posedge clk_sys);
			for (int p = 0; p < 4; p++)
				mux_exp[p] = mux_sel[p*3+:3] == 3'h7 ? 1'b0 : mux_data[p*7+mux_sel[p*3+:3]];
			@(posedge clk_sys);
			check(mux_out, mux_exp, "mux");
		end
		boot_run(4'h0, 1'b0, 1'b0);
		boot_run(4'h6, 1'b1, 1'b0);
		boot_run(4'h3, 1'b1, 1'b1);
		boot_run(4'h2, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rst_pins.external_warm_reset_n <= i[0];
			rst_pins.jtag_trst_n <= i[1];
			repeat (6) @(posedge clk_sys);
			check(warm_n, i[0], "warm reset");
			check(emu_n, i[1], "emu reset");
			check(en, 1'b1, "enable kept");
		end
		rst_pins.pmic_cold_reset_in <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check(hard, 1'b1, "cold reset");
		check(por_oe, 1'b1, "node pull");
		repeat (4) @(posedge clk_sys);
		check(en, 1'b0, "enable cleared");
		end_sim;
	end
	// Watchdog
	initial begin
		#2000000;
		mismatches++;
		end_sim;
	end
endmodule
